// *** include/srwg_defines.svh ***
// Constants for the special register write guard: register indices,
// field positions, operation codes and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SRWG_DEFINES_SVH
`define SRWG_DEFINES_SVH

// Bus geometry: byte address, one 32-bit word per register
`define SRWG_ADDR_W        6
`define SRWG_DATA_W        32
`define SRWG_BE_W          4
`define SRWG_IDX_MSB       5
`define SRWG_IDX_LSB       2
`define SRWG_IDX_W         4

// Register indices (byte address = index * 4)
`define SRWG_PROT_NUM      8
`define SRWG_IDX_PROT_LAST 4'h7
`define SRWG_IDX_CMD       4'h8
`define SRWG_IDX_SYS       4'h9
`define SRWG_IDX_ISTAT     4'hA
`define SRWG_IDX_IMASK     4'hB

// Field positions
`define SRWG_SYS_ERR_BIT   0
`define SRWG_BE_LOW_LANE   0
`define SRWG_IRQ_W         2
`define SRWG_IRQ_ERR_BIT   0
`define SRWG_IRQ_OK_BIT    1

// Write operation codes on the bit operation sideband
`define SRWG_OP_STORE      2'h0
`define SRWG_OP_SET        2'h1
`define SRWG_OP_CLR        2'h2
`define SRWG_OP_NOT        2'h3

// Reset values
`define SRWG_PROT_RST      8'h00
`define SRWG_ZERO32        32'h00000000
`define SRWG_IRQ_RST       2'h0

`endif

// *** include/srwg_pkg.sv ***
// Types shared by the special register write guard modules.
// Assumes srwg_defines.svh is on the include path.
`include "srwg_defines.svh"

package srwg_pkg;

    typedef logic [1:0]             srwg_op_t;
    typedef logic [`SRWG_IDX_W-1:0] srwg_idx_t;

    // State of the guard and its bus slave; protected register values live in srwg_prot_reg
    typedef struct packed {
        logic                      waitreq;
        logic [`SRWG_DATA_W-1:0]   rdata;
        logic                      armed;
        logic                      err_flag;
        logic [`SRWG_IRQ_W-1:0]    irq_stat;
        logic [`SRWG_IRQ_W-1:0]    irq_mask;
        logic                      irq;
    } srwg_guard_s;

endpackage : srwg_pkg

// *** rtl/srwg_prot_reg.sv ***
// One protected register: whole store or single-bit set, clear, invert.
// Assumes the caller has already decided that the write is legal.
`timescale 1ns/1ps
`include "srwg_defines.svh"

module srwg_prot_reg #(
    parameter int               REG_W   = 8,
    parameter logic [REG_W-1:0] RST_VAL = '0
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                wr_en,
    input  wire logic [REG_W-1:0]    wr_data,
    input  wire srwg_pkg::srwg_op_t  op,
    input  wire logic [2:0]          bit_index,
    output logic      [REG_W-1:0]    q
);

    typedef struct packed {
        logic [REG_W-1:0] value;
    } srwg_reg_s;

    srwg_reg_s        s_ff;
    srwg_reg_s        nxt_s;
    logic [REG_W-1:0] bit_mask;

    // Out-of-range bit index gives an empty mask, so nothing changes
    assign bit_mask = REG_W'(1) << bit_index;

    // Apply the requested operation
    always_comb begin
        nxt_s = s_ff;
        if (wr_en) begin
            case (op)
                `SRWG_OP_STORE: nxt_s.value = wr_data;
                `SRWG_OP_SET:   nxt_s.value = s_ff.value | bit_mask;
                `SRWG_OP_CLR:   nxt_s.value = s_ff.value & ~bit_mask;
                `SRWG_OP_NOT:   nxt_s.value = s_ff.value ^ bit_mask;
                default:        nxt_s.value = s_ff.value;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_ff.value <= RST_VAL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.value;

endmodule : srwg_prot_reg

// *** rtl/srwg_guard.sv ***
// Special register write guard with its Avalon-MM register slave.
// Assumes one CPU-side master on core_clk; sideband bit operation inputs
// are driven from core_clk logic alongside each write.
//
// Functional notes
// - Eight critical registers are write protected.
// - A protected write only succeeds right after a command register write.
// - An out-of-order protected store raises the error flag.
// - Stores and single-bit set, clear, invert all count as protected writes.
// - Interrupt acknowledge is held off while an unlock is pending.
// - Protected registers read freely, without touching the protection state.
// - Command register is write-only; reads return filler data.
// - Error also when a command write precedes a non-protected write.
// - Error flag clears on reset or zero write, even right after command.
// - Reads between command and protected write leave the unlock intact.
`timescale 1ns/1ps
`include "srwg_defines.svh"

module srwg_guard #(
    parameter int REG_W = 8
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [`SRWG_ADDR_W-1:0]  avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [`SRWG_DATA_W-1:0]  avs_writedata,
    input  wire logic [`SRWG_BE_W-1:0]    avs_byteenable,
    output logic      [`SRWG_DATA_W-1:0]  avs_readdata,
    output logic                          avs_waitrequest,
    input  wire srwg_pkg::srwg_op_t       bitop_kind,
    input  wire logic [2:0]               bitop_index,
    output logic                          int_hold,
    output logic                          irq,
    output logic      [REG_W-1:0]         power_save_control_reg,
    output logic      [REG_W-1:0]         clock_control_reg,
    output logic      [REG_W-1:0]         processor_clock_control_reg,
    output logic      [REG_W-1:0]         clock_monitor_mode_reg,
    output logic      [REG_W-1:0]         reset_source_flag_reg,
    output logic      [REG_W-1:0]         low_voltage_detect_reg,
    output logic      [REG_W-1:0]         ram_data_status_reg,
    output logic      [REG_W-1:0]         debug_mode_setting_reg
);

    // Bit operations address at most eight bit positions
    if (REG_W < 2 || REG_W > 8) begin : g_bad_width
        $error("srwg_guard: REG_W must be between 2 and 8");
    end

    srwg_pkg::srwg_guard_s  s_ff;
    srwg_pkg::srwg_guard_s  nxt_s;
    srwg_pkg::srwg_idx_t    idx;
    logic [2:0]             sel;
    logic                   acc_wr;
    logic                   acc_rd;
    logic                   hit_prot;
    logic                   hit_cmd;
    logic                   hit_sys;
    logic                   hit_istat;
    logic                   hit_imask;
    logic                   be_low;
    logic                   sys_zero;
    logic                   err_set;
    logic                   err_clr;
    logic                   ev_ok;
    logic [`SRWG_IRQ_W-1:0] istat_clr;
    logic [`SRWG_DATA_W-1:0] rd_mux;
    logic [`SRWG_PROT_NUM-1:0] prot_we;
    logic [REG_W-1:0]       prot_q [`SRWG_PROT_NUM];

    // Address decode
    assign idx       = avs_address[`SRWG_IDX_MSB:`SRWG_IDX_LSB];
    assign sel       = idx[2:0];
    assign hit_prot  = (idx <= `SRWG_IDX_PROT_LAST);
    assign hit_cmd   = (idx == `SRWG_IDX_CMD);
    assign hit_sys   = (idx == `SRWG_IDX_SYS);
    assign hit_istat = (idx == `SRWG_IDX_ISTAT);
    assign hit_imask = (idx == `SRWG_IDX_IMASK);
    assign be_low    = avs_byteenable[`SRWG_BE_LOW_LANE];

    // An access completes at the edge where waitrequest is seen low
    assign acc_wr = avs_write & ~s_ff.waitreq;
    assign acc_rd = avs_read & ~s_ff.waitreq;

    // Protected write strobes; the register array itself
    for (genvar g = 0; g < `SRWG_PROT_NUM; g++) begin : g_prot
        assign prot_we[g] = acc_wr & hit_prot & s_ff.armed & (sel == 3'(g));
        srwg_prot_reg #(
            .REG_W   (REG_W),
            .RST_VAL (REG_W'(`SRWG_PROT_RST))
        ) u_reg (
            .core_clk  (core_clk),
            .rst       (rst),
            .wr_en     (prot_we[g] & be_low),
            .wr_data   (avs_writedata[REG_W-1:0]),
            .op        (bitop_kind),
            .bit_index (bitop_index),
            .q         (prot_q[g])
        );
    end

    assign ev_ok = |prot_we;

    // Error flag: zero write to status clears even with an unlock pending
    assign sys_zero = hit_sys & be_low & ~avs_writedata[`SRWG_SYS_ERR_BIT];
    assign err_set  = acc_wr & ((hit_prot & ~s_ff.armed)
                      | (s_ff.armed & ~hit_prot & ~sys_zero));
    assign err_clr  = acc_wr & sys_zero;

    assign istat_clr = (acc_wr & hit_istat & be_low) ?
                       avs_writedata[`SRWG_IRQ_W-1:0] : `SRWG_IRQ_RST;

    // Read data mux; command register reads as zero filler
    always_comb begin
        rd_mux = `SRWG_ZERO32;
        if (hit_prot) begin
            rd_mux = `SRWG_DATA_W'(prot_q[sel]);
        end else if (hit_sys) begin
            rd_mux[`SRWG_SYS_ERR_BIT] = s_ff.err_flag;
        end else if (hit_istat) begin
            rd_mux[`SRWG_IRQ_W-1:0] = s_ff.irq_stat;
        end else if (hit_imask) begin
            rd_mux[`SRWG_IRQ_W-1:0] = s_ff.irq_mask;
        end else begin
            rd_mux = `SRWG_ZERO32;
        end
    end

    // Next state
    always_comb begin
        nxt_s = s_ff;
        // One wait state per access, then release
        nxt_s.waitreq = ~((avs_read | avs_write) & s_ff.waitreq);
        if (avs_read & s_ff.waitreq) begin
            nxt_s.rdata = rd_mux;
        end
        // Any write decides the unlock; reads leave it alone
        if (acc_wr) begin
            nxt_s.armed = hit_cmd;
        end
        if (err_set) begin
            nxt_s.err_flag = 1'b1;
        end else if (err_clr) begin
            nxt_s.err_flag = 1'b0;
        end
        // Set wins over write-one-to-clear
        nxt_s.irq_stat = (s_ff.irq_stat & ~istat_clr);
        nxt_s.irq_stat[`SRWG_IRQ_ERR_BIT] = nxt_s.irq_stat[`SRWG_IRQ_ERR_BIT] | err_set;
        nxt_s.irq_stat[`SRWG_IRQ_OK_BIT]  = nxt_s.irq_stat[`SRWG_IRQ_OK_BIT] | ev_ok;
        if (acc_wr & hit_imask & be_low) begin
            nxt_s.irq_mask = avs_writedata[`SRWG_IRQ_W-1:0];
        end
        nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_ff.waitreq  <= 1'b1;
            s_ff.rdata    <= `SRWG_ZERO32;
            s_ff.armed    <= 1'b0;
            s_ff.err_flag <= 1'b0;
            s_ff.irq_stat <= `SRWG_IRQ_RST;
            s_ff.irq_mask <= `SRWG_IRQ_RST;
            s_ff.irq      <= 1'b0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from flops
    assign avs_readdata    = s_ff.rdata;
    assign avs_waitrequest = s_ff.waitreq;
    assign int_hold        = s_ff.armed;
    assign irq             = s_ff.irq;
    assign power_save_control_reg      = prot_q[0];
    assign clock_control_reg           = prot_q[1];
    assign processor_clock_control_reg = prot_q[2];
    assign clock_monitor_mode_reg      = prot_q[3];
    assign reset_source_flag_reg       = prot_q[4];
    assign low_voltage_detect_reg      = prot_q[5];
    assign ram_data_status_reg         = prot_q[6];
    assign debug_mode_setting_reg      = prot_q[7];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_locked_store: assert property (
        acc_wr && hit_prot && !s_ff.armed |-> !ev_ok ##1 s_ff.err_flag)
        else $error("locked protected store not flagged or let through");

    a_unlock_write: assert property (
        acc_wr && hit_prot && s_ff.armed |=> s_ff.irq_stat[`SRWG_IRQ_OK_BIT] && !s_ff.armed)
        else $error("unlocked protected write not taken");

    a_bitop_set: assert property (
        acc_wr && hit_prot && s_ff.armed && be_low && bitop_kind == `SRWG_OP_SET
        |=> prot_q[$past(sel)][$past(bitop_index)])
        else $error("bit set on protected register lost");

    a_cmd_arms: assert property (
        acc_wr && hit_cmd |=> s_ff.armed && int_hold)
        else $error("command write did not arm unlock");

    a_read_keeps: assert property (
        acc_rd |=> $stable(s_ff.armed) && $stable(s_ff.err_flag))
        else $error("read changed protection state");

    a_cmd_twice: assert property (
        acc_wr && hit_cmd && s_ff.armed |=> s_ff.err_flag)
        else $error("second command write not flagged");

    a_zero_clears: assert property (
        acc_wr && sys_zero |=> !s_ff.err_flag)
        else $error("zero write did not clear error flag");

    a_hold_quiet: assert property (
        !s_ff.armed && !(acc_wr && hit_cmd) |=> !int_hold)
        else $error("interrupt hold without pending unlock");

    a_cmd_reads: assert property (
        s_ff.waitreq && avs_read && hit_cmd |=> avs_readdata == `SRWG_ZERO32 && !avs_waitrequest)
        else $error("command register read not zero");

    a_irq_level: assert property (
        irq == |(s_ff.irq_stat & s_ff.irq_mask))
        else $error("interrupt output disagrees with status and mask");

endmodule : srwg_guard

// *** sim/srwg_guard_tb.sv ***
// Self-checking bench for the special register write guard: directed
// corner cases, then seeded random traffic, all judged by a bench model.
// Assumes srwg_pkg and srwg_defines.svh are compiled ahead of this file.
`timescale 1ns/1ps
`include "srwg_defines.svh"

module srwg_guard_tb;
    logic               core_clk;
    logic               rst;
    logic [5:0]         avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [3:0]         avs_byteenable;
    wire  [31:0]        avs_readdata;
    wire                avs_waitrequest;
    srwg_pkg::srwg_op_t bitop_kind;
    logic [2:0]         bitop_index;
    wire                int_hold;
    wire                irq;
    wire  [7:0]         pq [8];
    logic [7:0]         m_reg [8];
    logic               m_arm;
    logic               m_err;
    logic [1:0]         m_ist;
    logic [1:0]         m_msk;
    int                 error_cnt = 0;
    int                 cmp_count = 0;
    int                 cyc = 0;
    logic [31:0]        r;

    srwg_guard dut (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bitop_kind(bitop_kind),
        .bitop_index(bitop_index), .int_hold(int_hold), .irq(irq),
        .power_save_control_reg(pq[0]), .clock_control_reg(pq[1]),
        .processor_clock_control_reg(pq[2]), .clock_monitor_mode_reg(pq[3]),
        .reset_source_flag_reg(pq[4]), .low_voltage_detect_reg(pq[5]),
        .ram_data_status_reg(pq[6]), .debug_mode_setting_reg(pq[7])
    );

    // Free-running core clock, 8 ns
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Hang guard: far above the roughly 1700 cycles the run needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Expected read data; command and unmapped places read zero
    function automatic logic [31:0] exp_rd(input logic [3:0] i);
        if (i <= `SRWG_IDX_PROT_LAST) return {24'h0, m_reg[i[2:0]]};
        if (i == `SRWG_IDX_SYS) return {31'h0, m_err};
        if (i == `SRWG_IDX_ISTAT) return {30'h0, m_ist};
        if (i == `SRWG_IDX_IMASK) return {30'h0, m_msk};
        return 32'h0;
    endfunction : exp_rd

    // Model of one accepted write; any write other than to the command register ends a pending unlock
    task automatic mdl_wr(input logic [3:0] i, input logic [31:0] d,
                          input logic [1:0] k, input logic [2:0] b);
        logic e;
        logic be;
        e = m_arm;
        // Low byte lane gates data, not the unlock sequencing
        be = avs_byteenable[`SRWG_BE_LOW_LANE];
        if (i <= `SRWG_IDX_PROT_LAST) begin
            e = !m_arm;
            if (m_arm && be) begin
                case (k)
                    `SRWG_OP_STORE: m_reg[i[2:0]] = d[7:0];
                    `SRWG_OP_SET:   m_reg[i[2:0]][b] = 1'b1;
                    `SRWG_OP_CLR:   m_reg[i[2:0]][b] = 1'b0;
                    default:        m_reg[i[2:0]][b] = ~m_reg[i[2:0]][b];
                endcase
            end
            if (m_arm) m_ist[1] = 1'b1;
        end else if (i == `SRWG_IDX_SYS) begin
            if (be && !d[0]) begin
                e = 1'b0;
                m_err = 1'b0;
            end
        end else if (i == `SRWG_IDX_ISTAT) begin
            if (be) m_ist = m_ist & ~d[1:0];
        end else if (i == `SRWG_IDX_IMASK) begin
            if (be) m_msk = d[1:0];
        end
        // Error event wins over a same-cycle status clear
        if (e) begin
            m_err = 1'b1;
            m_ist[0] = 1'b1;
        end
        m_arm = (i == `SRWG_IDX_CMD);
    endtask : mdl_wr

    // One Avalon-MM access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d,
                       input logic [1:0] k, input logic [2:0] b);
        int n;
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= {i, 2'h0};
        avs_writedata <= d;
        bitop_kind <= k;
        bitop_index <= b;
        @(posedge core_clk);
        for (n = 0; n < 8; n++) chk({24'h0, pq[n]}, {24'h0, m_reg[n]});
        chk({31'h0, int_hold}, {31'h0, m_arm});
        chk({31'h0, irq}, {31'h0, |(m_ist & m_msk)});
        // No assumed latency: only the bench timeout ends this wait
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        if (!w) chk(avs_readdata, exp_rd(i));
        else mdl_wr(i, d, k, b);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test

    initial begin
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        bitop_kind = `SRWG_OP_STORE;
        bitop_index = 3'h0;
        for (int j = 0; j < 8; j++) m_reg[j] = `SRWG_PROT_RST;
        {m_arm, m_err, m_ist, m_msk} = '0;
        void'($urandom(87424));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        // Reset contents of every place, unmapped included
        for (int j = 0; j < 16; j++) bus(1'b0, j[3:0], 32'h0, 2'h0, 3'h0);
        bus(1'b1, 4'h2, 32'h5A, `SRWG_OP_STORE, 3'h0);
        bus(1'b1, `SRWG_IDX_SYS, 32'h1, 2'h0, 3'h0);
        bus(1'b0, `SRWG_IDX_SYS, 32'h0, 2'h0, 3'h0);
        bus(1'b1, `SRWG_IDX_SYS, 32'h0, 2'h0, 3'h0);
        bus(1'b1, `SRWG_IDX_IMASK, 32'h3, 2'h0, 3'h0);
        // Unlock each protected place with reads in between; the bench is
        // the only master, so no other transfer cuts into the sequence
        for (int j = 0; j < 8; j++) begin
            r = $urandom;
            bus(1'b1, `SRWG_IDX_CMD, r, 2'h0, 3'h0);
            bus(1'b0, j[3:0], 32'h0, 2'h0, 3'h0);
            bus(1'b0, `SRWG_IDX_CMD, 32'h0, 2'h0, 3'h0);
            bus(1'b1, j[3:0], r, `SRWG_OP_STORE, 3'h0);
            if (j == 0) repeat (5) @(posedge core_clk);
        end
        for (int j = 1; j < 4; j++) begin
            r = $urandom;
            bus(1'b1, `SRWG_IDX_CMD, 32'h0, 2'h0, 3'h0);
            bus(1'b1, 4'h5, r, j[1:0], r[2:0]);
        end
        bus(1'b1, `SRWG_IDX_CMD, 32'h0, 2'h0, 3'h0);
        bus(1'b1, 4'hC, 32'hFF, 2'h0, 3'h0);
        bus(1'b1, `SRWG_IDX_CMD, 32'h0, 2'h0, 3'h0);
        bus(1'b1, `SRWG_IDX_CMD, 32'h0, 2'h0, 3'h0);
        bus(1'b1, `SRWG_IDX_SYS, 32'h0, 2'h0, 3'h0);
        bus(1'b1, `SRWG_IDX_ISTAT, 32'h3, 2'h0, 3'h0);
        // Random mix, with frequent unlock attempts
        for (int j = 0; j < 400; j++) begin
            r = $urandom;
            // Low lane dropped now and then: sequencing without data
            avs_byteenable <= {3'h7, r[12] | r[13]};
            if (r[11:10] == 2'h0) bus(1'b1, `SRWG_IDX_CMD, 32'h0, 2'h0, 3'h0);
            bus(r[0], r[4:1], $urandom, r[6:5], r[9:7]);
        end
        // Closing read so the last write's effects are compared too
        bus(1'b0, `SRWG_IDX_SYS, 32'h0, 2'h0, 3'h0);
        finish_test();
    end
endmodule : srwg_guard_tb
